/* rtl/ual_pkg.sv */
// Package with offsets, layouts, reset values, counts and states of the line-mode transceiver
package ual_pkg;
  // Byte offsets of the register words
  localparam logic [4:0] ADR_CTRL = 5'h00;
  localparam logic [4:0] ADR_STAT = 5'h04;
  localparam logic [4:0] ADR_DATA = 5'h08;
  localparam logic [4:0] ADR_BAUD = 5'h0C;
  localparam logic [4:0] ADR_GTPR = 5'h10;
  // Status bit positions
  localparam int ST_TC = 0;
  localparam int ST_TXE = 1;
  localparam int ST_RXNE = 2;
  localparam int ST_PE = 3;
  localparam int ST_FE = 4;
  localparam int ST_BRK = 5;
  // Reset values
  localparam logic [15:0] BAUD_RST = 16'h0010;
  localparam logic [15:0] GTPR_RST = 16'h0000;
  // Counts in sixteenth-bit ticks
  localparam logic [5:0] TK_BIT = 6'h10;
  localparam logic [5:0] TK_HALF = 6'h08;
  localparam logic [5:0] TK_MID = 6'h07;
  localparam logic [5:0] TK_STOP15 = 6'h18;
  localparam logic [5:0] TK_PARITY_REJECT_ENABLE = 6'h10;
  localparam logic [5:0] TK_BLANK = 6'h30;
  // Infrared pulse length in ticks or low-power periods
  localparam logic [1:0] IR_PULSE = 2'h3;
  // Bits per frame after the start bit, and sent bits per frame
  localparam logic [3:0] RXB_PAR = 4'hA;
  localparam logic [3:0] RXB_NOPAR = 4'h9;
  localparam logic [3:0] TXB_PAR = 4'hB;
  localparam logic [3:0] TXB_NOPAR = 4'hA;
  // Control word layout, bit 0 last
  typedef struct packed {
    logic lin_bus_select;
    logic sync_clock_output_select;
    logic irda_lowpower;
    logic parity_reject_enable;
    logic infrared_select;
    logic smartcard_select;
    logic one_wire_duplex_select;
    logic stop15;
    logic parity_odd;
    logic parity_on;
    logic rx_en;
    logic tx_en;
  } ual_ctrl_t;
  localparam ual_ctrl_t CTRL_RST = '0;
  // Transmit states
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000, TX_DLY = 3'b001, TX_SHIFT = 3'b010, TX_GUARD = 3'b011, TX_PARITY_REJECT_ENABLE = 3'b100
  } ual_tx_t;
  // Receive states
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00, RX_START = 2'b01, RX_BITS = 2'b10, RX_BLANK = 2'b11
  } ual_rx_t;
endpackage

/* rtl/ual_line_modes.sv */
// Serial transceiver with one-wire, smartcard and infrared line modes
// How it works
// - Half duplex frees pin when not sending
// - Half duplex never blocks transmission
// - Smartcard start delayed extra half bit
// - Parity fault sends one-bit low reject
// - Guard count delays transmit-done rise
// - Transmit-done clears alike in every mode
// - Reject pulse never seen as start
// - Smartcard zero with framing error is data
// - Smartcard sends no idle frame
// - Smartcard clock is divided peripheral clock
// - Zero sent as 3/16 high pulse
// - Infrared output rests low
// - Decoder maps low pulses to zeros
// - Infrared is half duplex both ways
// - Glitch filter drops short low pulses
// - Infrared off when divider is zero
// - Low-power pulse is three divider periods
// - Parity failure outside a break frame sets parity fault flag
//
// The implementer's own choices: the address map and register access over Avalon-MM.
module ual_line_modes
  import ual_pkg::*;
(
  input logic mclk_i,
  input logic rst_i,
  input logic [4:0] avs_address_i,
  input logic avs_read_i,
  input logic avs_write_i,
  input logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input logic rx_i,
  input logic tx_i,
  output logic tx_o,
  output logic tx_oe_o,
  output logic ck_o
);
  // Pin synchronisers
  logic rx_m_reg, rx_s_reg, ln_m_reg, ln_s_reg;
  // Registers seen by software
  ual_ctrl_t ctrl_reg;
  logic [15:0] baud_reg, gtpr_reg;
  logic [7:0] thr_reg, rdr_reg;
  logic thr_full_reg, tc_reg, rxne_reg, pe_reg, fe_reg, brk_reg;
  // Bus handshake
  logic wait_reg;
  logic [31:0] rdata_reg, rd_mux;
  logic acc, wr_take, rd_take;
  // Mode selection
  logic ir, sc, hd;
  logic [7:0] irda_divider, guard;
  // Baud ticks
  logic [15:0] bcnt_reg;
  logic tick_reg;
  // Transmitter
  ual_tx_t tx_st_reg;
  logic [10:0] tsr_reg;
  logic [3:0] tbits_reg;
  logic [5:0] tph_reg, blen;
  logic [7:0] gcnt_reg;
  logic te_d_reg, idle_pend_reg, parity_reject_enable_req_reg;
  logic ld, par_bit, tx_end, g_done, tc_set, tx_line, tx_busy;
  // Receiver
  ual_rx_t rx_st_reg;
  logic [5:0] rph_reg;
  logic [3:0] rbits_reg, rx_nb;
  logic [9:0] rsr_reg, nxt;
  logic [7:0] rdat;
  logic rx_bit, line_in, r_pe, r_fe, r_brk, rx_done;
  // Infrared codec
  logic [7:0] pcnt_reg;
  logic lp_tick_reg;
  logic [1:0] ipc_reg;
  logic [8:0] lcnt_reg;
  logic [5:0] dstr_reg;
  logic ir_dec_reg, accept, ir_kick;
  // Card clock divider
  logic [4:0] ckc_reg;
  logic ckt_reg;

  // Two flip-flops on each pin input
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_m_reg <= 1'b1;
      rx_s_reg <= 1'b1;
      ln_m_reg <= 1'b1;
      ln_s_reg <= 1'b1;
    end else begin
      rx_m_reg <= rx_i;
      rx_s_reg <= rx_m_reg;
      ln_m_reg <= tx_i;
      ln_s_reg <= ln_m_reg;
    end
  end

  // One mode at a time, infrared first
  assign ir = ctrl_reg.infrared_select;
  assign sc = ctrl_reg.smartcard_select & ~ir;
  assign hd = ctrl_reg.one_wire_duplex_select & ~ir & ~sc;
  assign irda_divider = gtpr_reg[7:0];
  assign guard = gtpr_reg[15:8];

  // Bus strobes: first cycle answers, second cycle takes
  assign acc = (avs_read_i | avs_write_i) & wait_reg;
  assign wr_take = avs_write_i & ~wait_reg;
  assign rd_take = avs_read_i & ~wait_reg;

  // Read data selection, unmapped reads zero
  always_comb begin
    rd_mux = '0;
    case (avs_address_i)
      ADR_CTRL: rd_mux = 32'(ctrl_reg);
      ADR_STAT: begin
        rd_mux[ST_TC] = tc_reg;
        rd_mux[ST_TXE] = ~thr_full_reg;
        rd_mux[ST_RXNE] = rxne_reg;
        rd_mux[ST_PE] = pe_reg;
        rd_mux[ST_FE] = fe_reg;
        rd_mux[ST_BRK] = brk_reg;
      end
      ADR_DATA: rd_mux = 32'(rdr_reg);
      ADR_BAUD: rd_mux = 32'(baud_reg);
      ADR_GTPR: rd_mux = 32'(gtpr_reg);
      default: rd_mux = '0;
    endcase
  end

  // Waitrequest drops for one cycle after each request
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wait_reg <= 1'b1;
      rdata_reg <= '0;
    end else begin
      wait_reg <= ~acc;
      if (acc) begin
        rdata_reg <= rd_mux;
      end
    end
  end
  assign avs_waitrequest_o = wait_reg;
  assign avs_readdata_o = rdata_reg;

  // Configuration words
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_reg <= CTRL_RST;
      baud_reg <= BAUD_RST;
      gtpr_reg <= GTPR_RST;
    end else if (wr_take) begin
      if (avs_address_i == ADR_CTRL) ctrl_reg <= ual_ctrl_t'(avs_writedata_i[11:0]);
      if (avs_address_i == ADR_BAUD) baud_reg <= avs_writedata_i[15:0];
      if (avs_address_i == ADR_GTPR) gtpr_reg <= avs_writedata_i[15:0];
    end
  end

  // Sixteenth-bit tick from the baud divisor
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      bcnt_reg <= '0;
      tick_reg <= 1'b0;
    end else if (baud_reg == 16'h0000 || bcnt_reg >= baud_reg - 16'h0001) begin
      bcnt_reg <= '0;
      tick_reg <= 1'b1;
    end else begin
      bcnt_reg <= bcnt_reg + 16'h0001;
      tick_reg <= 1'b0;
    end
  end

  // Transmit control terms
  assign ld = (tx_st_reg == TX_IDLE) & tick_reg & ctrl_reg.tx_en & (thr_full_reg | idle_pend_reg) & ~parity_reject_enable_req_reg;
  assign par_bit = (^thr_reg) ^ ctrl_reg.parity_odd;
  assign blen = (tbits_reg == 4'h1 && ctrl_reg.stop15) ? TK_STOP15 : TK_BIT;
  assign tx_end = (tx_st_reg == TX_SHIFT) & tick_reg & (tph_reg == blen - 6'h01) & (tbits_reg == 4'h1);
  assign g_done = (tx_st_reg == TX_GUARD) & tick_reg & (tph_reg == TK_BIT - 6'h01) & (gcnt_reg == guard - 8'h01);
  // Done rises at once, or after the guard count in smartcard mode
  assign tc_set = (tx_end & ~thr_full_reg & (~sc | guard == 8'h00)) | (g_done & ~thr_full_reg);
  assign tx_line = (tx_st_reg == TX_PARITY_REJECT_ENABLE) ? 1'b0 : (tx_st_reg == TX_SHIFT) ? tsr_reg[0] : 1'b1;
  assign tx_busy = (tx_st_reg == TX_SHIFT) | (tx_st_reg == TX_PARITY_REJECT_ENABLE);

  // Holding register, idle request and reject request
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      thr_reg <= '0;
      thr_full_reg <= 1'b0;
      te_d_reg <= 1'b0;
      idle_pend_reg <= 1'b0;
      parity_reject_enable_req_reg <= 1'b0;
    end else begin
      te_d_reg <= ctrl_reg.tx_en;
      // Accepted whatever the line does
      if (wr_take && avs_address_i == ADR_DATA) begin
        thr_reg <= avs_writedata_i[7:0];
        thr_full_reg <= 1'b1;
      end else if (ld && !idle_pend_reg) begin
        thr_full_reg <= 1'b0;
      end
      // Idle frame only outside smartcard mode
      if (ctrl_reg.tx_en && !te_d_reg && !sc) begin
        idle_pend_reg <= 1'b1;
      end else if (ld) begin
        idle_pend_reg <= 1'b0;
      end
      // Reject request set by a faulty frame
      if (rx_done && sc && ctrl_reg.parity_reject_enable && r_pe) begin
        parity_reject_enable_req_reg <= 1'b1;
      end else if (tx_st_reg == TX_IDLE && tick_reg) begin
        parity_reject_enable_req_reg <= 1'b0;
      end
    end
  end

  // Transmit state machine
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_st_reg <= TX_IDLE;
      tsr_reg <= '1;
      tbits_reg <= '0;
      tph_reg <= '0;
      gcnt_reg <= '0;
    end else begin
      unique case (tx_st_reg)
        TX_IDLE: begin
          tph_reg <= '0;
          if (ld) begin
            if (idle_pend_reg) tsr_reg <= '1;
            else if (ctrl_reg.parity_on) tsr_reg <= {1'b1, par_bit, thr_reg, 1'b0};
            else tsr_reg <= {2'b11, thr_reg, 1'b0};
            tbits_reg <= ctrl_reg.parity_on ? TXB_PAR : TXB_NOPAR;
            tx_st_reg <= sc ? TX_DLY : TX_SHIFT;
          end else if (parity_reject_enable_req_reg && tick_reg) begin
            tx_st_reg <= TX_PARITY_REJECT_ENABLE;
          end
        end
        // Extra half bit before shifting
        TX_DLY: if (tick_reg) begin
          if (tph_reg == TK_HALF - 6'h01) begin
            tph_reg <= '0;
            tx_st_reg <= TX_SHIFT;
          end else tph_reg <= tph_reg + 6'h01;
        end
        TX_SHIFT: if (tick_reg) begin
          if (tph_reg == blen - 6'h01) begin
            tph_reg <= '0;
            tsr_reg <= {1'b1, tsr_reg[10:1]};
            tbits_reg <= tbits_reg - 4'h1;
            gcnt_reg <= '0;
            if (tbits_reg == 4'h1) begin
              tx_st_reg <= (sc && !thr_full_reg && guard != 8'h00) ? TX_GUARD : TX_IDLE;
            end
          end else tph_reg <= tph_reg + 6'h01;
        end
        // Guard count per bit; a new load ends it
        TX_GUARD: if (thr_full_reg) begin
          tx_st_reg <= TX_IDLE;
        end else if (tick_reg) begin
          if (tph_reg == TK_BIT - 6'h01) begin
            tph_reg <= '0;
            gcnt_reg <= gcnt_reg + 8'h01;
            if (g_done) tx_st_reg <= TX_IDLE;
          end else tph_reg <= tph_reg + 6'h01;
        end
        // Line low for one bit
        TX_PARITY_REJECT_ENABLE: if (tick_reg) begin
          if (tph_reg == TK_PARITY_REJECT_ENABLE - 6'h01) tx_st_reg <= TX_IDLE;
          else tph_reg <= tph_reg + 6'h01;
        end
        default: tx_st_reg <= TX_IDLE;
      endcase
    end
  end

  // Receive data source and frame decode
  assign line_in = (hd | sc) ? ln_s_reg : rx_s_reg;
  assign rx_bit = ir ? ir_dec_reg : line_in;
  assign rx_nb = ctrl_reg.parity_on ? RXB_PAR : RXB_NOPAR;
  assign nxt = {rx_bit, rsr_reg[9:1]};
  assign rdat = ctrl_reg.parity_on ? nxt[7:0] : nxt[8:1];
  assign r_pe = ctrl_reg.parity_on & ((^nxt[8:0]) ^ ctrl_reg.parity_odd);
  assign r_fe = ~rx_bit;
  assign r_brk = r_fe & (rdat == 8'h00) & ~sc;
  assign rx_done = (rx_st_reg == RX_BITS) & tick_reg & (rph_reg == TK_BIT - 6'h01) & (rbits_reg == rx_nb - 4'h1);

  // Receive state machine
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_st_reg <= RX_IDLE;
      rph_reg <= '0;
      rbits_reg <= '0;
      rsr_reg <= '0;
    end else begin
      unique case (rx_st_reg)
        RX_IDLE: begin
          rph_reg <= '0;
          if (tick_reg && ctrl_reg.rx_en && !rx_bit && tx_st_reg != TX_PARITY_REJECT_ENABLE) rx_st_reg <= RX_START;
        end
        RX_START: if (tick_reg) begin
          if (rph_reg == TK_MID) begin
            rph_reg <= '0;
            rbits_reg <= '0;
            rx_st_reg <= rx_bit ? RX_IDLE : RX_BITS;
          end else rph_reg <= rph_reg + 6'h01;
        end
        RX_BITS: if (tick_reg) begin
          if (rph_reg == TK_BIT - 6'h01) begin
            rph_reg <= '0;
            rsr_reg <= nxt;
            rbits_reg <= rbits_reg + 4'h1;
            if (rx_done) rx_st_reg <= sc ? RX_BLANK : RX_IDLE;
          end else rph_reg <= rph_reg + 6'h01;
        end
        // Start search held off over any reject pulse
        RX_BLANK: if (tick_reg) begin
          if (rph_reg == TK_BLANK - 6'h01) rx_st_reg <= RX_IDLE;
          else rph_reg <= rph_reg + 6'h01;
        end
        default: rx_st_reg <= RX_IDLE;
      endcase
    end
  end

  // Status flags; a set in the clearing cycle wins
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      tc_reg <= 1'b1;
      rxne_reg <= 1'b0;
      pe_reg <= 1'b0;
      fe_reg <= 1'b0;
      brk_reg <= 1'b0;
      rdr_reg <= '0;
    end else begin
      // Same clearing in every mode
      if (wr_take && avs_address_i == ADR_DATA) tc_reg <= 1'b0;
      if (wr_take && avs_address_i == ADR_STAT) begin
        if (avs_writedata_i[ST_TC]) tc_reg <= 1'b0;
        if (avs_writedata_i[ST_PE]) pe_reg <= 1'b0;
        if (avs_writedata_i[ST_FE]) fe_reg <= 1'b0;
        if (avs_writedata_i[ST_BRK]) brk_reg <= 1'b0;
      end
      if (rd_take && avs_address_i == ADR_DATA) rxne_reg <= 1'b0;
      if (tc_set) tc_reg <= 1'b1;
      if (rx_done) begin
        if (r_brk) brk_reg <= 1'b1;
        else begin
          rdr_reg <= rdat;
          rxne_reg <= 1'b1;
          if (r_pe) pe_reg <= 1'b1;
          if (r_fe) fe_reg <= 1'b1;
        end
      end
    end
  end

  // Encoder pulse launch: first tick of each zero bit
  assign ir_kick = tick_reg & (tx_st_reg == TX_SHIFT) & (tph_reg == 6'h00) & ~tsr_reg[0];

  // Low-power period tick from the divider, restarted at each launch so a pulse spans whole periods
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pcnt_reg <= '0;
      lp_tick_reg <= 1'b0;
    end else if (irda_divider == 8'h00) begin
      pcnt_reg <= '0;
      lp_tick_reg <= 1'b0;
    end else if (ir_kick) begin
      // Next period tick lands exactly one divider period after the launch
      pcnt_reg <= 8'h01;
      lp_tick_reg <= (irda_divider == 8'h01);
    end else if (pcnt_reg >= irda_divider - 8'h01) begin
      pcnt_reg <= '0;
      lp_tick_reg <= 1'b1;
    end else begin
      pcnt_reg <= pcnt_reg + 8'h01;
      lp_tick_reg <= 1'b0;
    end
  end

  // Encoder pulse: three ticks, or three low-power periods
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ipc_reg <= '0;
    end else if (ir_kick) begin
      ipc_reg <= IR_PULSE;
    end else if ((ctrl_reg.irda_lowpower ? lp_tick_reg : tick_reg) && ipc_reg != 2'h0) begin
      ipc_reg <= ipc_reg - 2'h1;
    end
  end

  // Glitch filter: a low counts once it lasts two divider periods
  assign accept = ~rx_s_reg & (lcnt_reg == {irda_divider, 1'b0} - 9'h001);
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      lcnt_reg <= '0;
      dstr_reg <= '0;
      ir_dec_reg <= 1'b1;
    end else begin
      if (rx_s_reg || tx_busy || irda_divider == 8'h00) lcnt_reg <= '0;
      else if (!accept) lcnt_reg <= lcnt_reg + 9'h001;
      // Accepted pulse stretched to a whole zero bit
      if (tx_busy || irda_divider == 8'h00) dstr_reg <= '0;
      else if (accept) dstr_reg <= TK_BIT;
      else if (tick_reg && dstr_reg != 6'h00) dstr_reg <= dstr_reg - 6'h01;
      ir_dec_reg <= (dstr_reg == 6'h00);
    end
  end

  // Card clock: divider count toggles, ratio two times the field
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ckc_reg <= '0;
      ckt_reg <= 1'b0;
      ck_o <= 1'b0;
    end else begin
      if (irda_divider[4:0] == 5'h00) begin
        ckc_reg <= '0;
        ckt_reg <= 1'b0;
      end else if (ckc_reg == irda_divider[4:0] - 5'h01) begin
        ckc_reg <= '0;
        ckt_reg <= ~ckt_reg;
      end else ckc_reg <= ckc_reg + 5'h01;
      ck_o <= sc & ctrl_reg.sync_clock_output_select & ckt_reg;
    end
  end

  // Line driver per mode
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_o <= 1'b1;
      tx_oe_o <= 1'b0;
    end else if (ir) begin
      tx_o <= (irda_divider != 8'h00) & (rx_st_reg == RX_IDLE) & (ipc_reg != 2'h0);
      tx_oe_o <= 1'b1;
    end else if (hd) begin
      tx_o <= tx_line;
      tx_oe_o <= tx_busy;
    end else if (sc) begin
      tx_o <= 1'b0;
      tx_oe_o <= ~tx_line;
    end else begin
      tx_o <= tx_line;
      tx_oe_o <= 1'b1;
    end
  end

  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence s_load_sc;
    (tx_st_reg == TX_IDLE) && ld && sc;
  endsequence
  a_hd_pin_release: assert property (hd && !tx_busy |=> !tx_oe_o)
    else $error("half duplex pin driven while idle");
  a_sc_half_delay: assert property (s_load_sc |=> tx_st_reg == TX_DLY)
    else $error("smartcard load skipped half bit delay");
  a_parity_reject_enable_line_low: assert property (sc && tx_st_reg == TX_PARITY_REJECT_ENABLE |=> tx_oe_o && !tx_o)
    else $error("reject pulse not driven low");
  a_tc_guard_hold: assert property (sc && tx_st_reg == TX_GUARD && !g_done |=> !$rose(tc_reg))
    else $error("done rose during guard time");
  a_tc_data_clear: assert property (wr_take && avs_address_i == ADR_DATA && !tc_set |=> !tc_reg)
    else $error("done not cleared by data write");
  a_brk_as_data: assert property (rx_done && sc && r_fe && rdat == 8'h00 |=> rxne_reg && !$rose(brk_reg))
    else $error("smartcard zero taken as break");
  a_ck_gated_off: assert property (!(sc && ctrl_reg.sync_clock_output_select) |=> !ck_o)
    else $error("card clock runs outside smartcard");
  a_ir_zero_div: assert property (ir && irda_divider == 8'h00 |=> !tx_o)
    else $error("encoder active with zero divider");
  a_ir_rx_mute: assert property (ir && tx_busy ##1 tx_busy |=> ir_dec_reg)
    else $error("decoder heard line while sending");
  a_pe_flag_set: assert property (rx_done && r_pe && !r_brk |=> pe_reg)
    else $error("parity fault not flagged");
endmodule // ual_line_modes

/* tb/ual_card_model.sv */
// Partner model: smartcard or infrared transceiver on the shared line
module ual_card_model (
  input wire logic mclk_i,
  input wire logic tx_o,
  input wire logic tx_oe_o,
  output logic rx_o,
  output logic line_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic card_lvl = 1'b1; // Card side of the wire, released high
  // Wire with pull-up: either party may only pull it low
  assign line_o = (tx_oe_o ? tx_o : 1'b1) & card_lvl;
  // Infrared detector output rests high in the marking state
  initial rx_o = 1'b1;
  // Card frame: start, 8 data LSB first, even parity, stop, then release
  task automatic send_frame(input logic [7:0] dv, input logic bad_par, input logic stop_low);
    logic [10:0] f;
    f = {~stop_low, (^dv) ^ bad_par, dv, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge mclk_i) card_lvl <= f[i];
      repeat (15) @(posedge mclk_i);
    end
    @(posedge mclk_i) card_lvl <= 1'b1;
  endtask
  // One low pulse of w cycles on the detector output
  task automatic ir_low(input int w);
    @(posedge mclk_i) rx_o <= 1'b0;
    repeat (w) @(posedge mclk_i);
    rx_o <= 1'b1;
  endtask
  // Infrared frame: a low pulse at the head of each zero bit
  task automatic ir_frame(input logic [7:0] dv, input int bitc, input int w);
    logic [9:0] f;
    f = {1'b1, dv, 1'b0};
    for (int i = 0; i < 10; i++) begin
      if (!f[i]) ir_low(w);
      else @(posedge mclk_i);
      repeat (bitc - (f[i] ? 1 : w + 1)) @(posedge mclk_i);
    end
  endtask
endmodule // ual_card_model

/* tb/ual_line_modes_test.sv */
// Self-checking bench for the line-mode transceiver
module ual_line_modes_test
  import ual_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {string nm; logic [31:0] ex; logic [31:0] mk;} ual_note_t; // Awaited read result
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [4:0] avs_address_i = '0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = '0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic rx_i;
  logic line;
  logic tx_o;
  logic tx_oe_o;
  logic ck_o;
  logic tx_q = 1'b0;
  logic [31:0] q;
  logic [7:0] d;
  ual_note_t notes[$];
  int n_fail = 0;
  int n_checks = 0;
  int oe_cyc, lo_cyc, hi_cyc, n_rise, el;
  integer seed = 32'h0000_90b7;
  realtime t0;
  // Clock, 5 ns period
  always #2.5 mclk_i = ~mclk_i;
  ual_line_modes uut (.mclk_i(mclk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .rx_i(rx_i),
    .tx_i(line), .tx_o(tx_o), .tx_oe_o(tx_oe_o), .ck_o(ck_o));
  ual_card_model card (.mclk_i(mclk_i), .tx_o(tx_o), .tx_oe_o(tx_oe_o), .rx_o(rx_i), .line_o(line));
  // Line statistics gathered every cycle
  always @(posedge mclk_i) begin
    if (tx_oe_o === 1'b1) oe_cyc++;
    if (tx_oe_o === 1'b1 && line === 1'b0) lo_cyc++;
    if (tx_o === 1'b1) hi_cyc++;
    if (tx_o === 1'b1 && tx_q === 1'b0) n_rise++;
    tx_q = tx_o;
  end
  // Compare one value and count it
  task automatic cmp(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_checks++;
    if (got !== ex) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // Monitor: each completed read takes the oldest note
  always @(posedge mclk_i) begin
    if (avs_read_i === 1'b1 && avs_waitrequest_o === 1'b0 && notes.size() > 0) begin
      cmp(notes[0].nm, notes[0].ex, avs_readdata_o & notes[0].mk);
      void'(notes.pop_front());
    end
  end
  // One bus cycle, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge mclk_i);
    avs_address_i <= a;
    avs_writedata_i <= wd;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do begin
      @(posedge mclk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (n >= 50) n_fail++;
  endtask
  // Read with an expected masked value
  task automatic chk(input string nm, input logic [4:0] a, input logic [31:0] ex, input logic [31:0] mk);
    notes.push_back('{nm, ex, mk});
    bus(1'b0, a, 32'h0000_0000);
  endtask
  // Restart line statistics away from the sampling edge
  task automatic clr();
    @(negedge mclk_i);
    oe_cyc = 0;
    lo_cyc = 0;
    hi_cyc = 0;
    n_rise = 0;
  endtask
  // Verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog cuts a hang short
  initial begin
    #200000;
    n_fail++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    repeat (16) @(posedge mclk_i);
    rst_i <= 1'b0;
    chk("ctrl reset", ADR_CTRL, 32'h0000_0000, 32'hFFFF_FFFF);
    chk("stat reset", ADR_STAT, 32'h0000_0003, 32'h0000_003F);
    chk("baud reset", ADR_BAUD, {16'h0000, BAUD_RST}, 32'hFFFF_FFFF);
    chk("guard reset", ADR_GTPR, {16'h0000, GTPR_RST}, 32'hFFFF_FFFF);
    bus(1'b1, 5'h14, 32'hFFFF_FFFF);
    chk("unmapped", 5'h14, 32'h0000_0000, 32'hFFFF_FFFF);
    bus(1'b1, ADR_BAUD, 32'h0000_0001);
    $display("test registers done");
    // One-wire half duplex: pin free in idle, driven only while sending
    bus(1'b1, ADR_CTRL, 32'h0000_002D);
    repeat (300) @(posedge mclk_i);
    clr();
    repeat (100) @(posedge mclk_i);
    cmp("idle drive", 0, oe_cyc);
    d = $random(seed);
    bus(1'b1, ADR_DATA, {24'h0, d});
    repeat (250) @(posedge mclk_i);
    cmp("frame drive", 176, oe_cyc);
    cmp("frame zeros", 16 * (9 - $countones(d) + (^d)), lo_cyc);
    $display("test half duplex done");
    // Smartcard: no idle frame, card clock, reject on parity fault
    bus(1'b1, ADR_CTRL, 32'h0000_0000);
    bus(1'b1, ADR_GTPR, 32'h0000_0203);
    bus(1'b1, ADR_CTRL, 32'h0000_0557);
    // Count only once the open-drain driver has taken over from normal mode
    @(posedge mclk_i);
    clr();
    repeat (200) @(posedge mclk_i);
    cmp("no idle frame", 0, oe_cyc);
    @(posedge ck_o);
    t0 = $realtime;
    @(posedge ck_o);
    cmp("card clock", 6, int'(($realtime - t0) / 5.0));
    d = $random(seed);
    clr();
    card.send_frame(d, 1'b1, 1'b0);
    repeat (60) @(posedge mclk_i);
    cmp("reject width", 16, oe_cyc);
    chk("parity flag", ADR_STAT, 32'h0000_0008, 32'h0000_0008);
    chk("card data", ADR_DATA, {24'h0, d}, 32'h0000_00FF);
    repeat (200) @(posedge mclk_i);
    chk("reject not start", ADR_STAT, 32'h0000_0000, 32'h0000_0004);
    bus(1'b1, ADR_STAT, 32'h0000_0038);
    clr();
    card.send_frame(8'h00, 1'b0, 1'b1);
    repeat (100) @(posedge mclk_i);
    chk("zero no break", ADR_STAT, 32'h0000_0004, 32'h0000_0024);
    chk("zero data", ADR_DATA, 32'h0000_0000, 32'h0000_00FF);
    cmp("no reject", 0, oe_cyc);
    d = $random(seed);
    t0 = $realtime;
    bus(1'b1, ADR_DATA, {24'h0, d});
    chk("done cleared", ADR_STAT, 32'h0000_0000, 32'h0000_0001);
    q = 32'h0;
    while (q[ST_TC] !== 1'b1) bus(1'b0, ADR_STAT, 32'h0);
    el = int'(($realtime - t0) / 5.0);
    cmp("guard delay", 1, (el >= 227 && el <= 240));
    bus(1'b0, ADR_DATA, 32'h0);
    $display("test smartcard done");
    // Infrared: pulse width per mode, divider zero silences the encoder
    bus(1'b1, ADR_BAUD, 32'h0000_0004);
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, ADR_CTRL, 32'h0000_0000);
      bus(1'b1, ADR_GTPR, (i == 1) ? 32'h0000_0002 : (i == 2) ? 32'h0000_0000 : 32'h0000_0004);
      bus(1'b1, ADR_CTRL, (i == 1) ? 32'h0000_0281 : 32'h0000_0081);
      repeat (700) @(posedge mclk_i);
      clr();
      cmp("ir idle low", 0, tx_o);
      d = $random(seed);
      bus(1'b1, ADR_DATA, {24'h0, d});
      repeat (700) @(posedge mclk_i);
      cmp("ir pulses", (i == 2) ? 0 : 9 - $countones(d), n_rise);
      cmp("ir width", (i == 2) ? 0 : (i == 1 ? 6 : 12) * (9 - $countones(d)), hi_cyc);
    end
    bus(1'b1, ADR_GTPR, 32'h0000_0004);
    bus(1'b1, ADR_CTRL, 32'h0000_0083);
    repeat (700) @(posedge mclk_i);
    card.ir_low(2);
    repeat (700) @(posedge mclk_i);
    chk("glitch dropped", ADR_STAT, 32'h0000_0000, 32'h0000_0004);
    d = $random(seed);
    card.ir_frame(d, 64, 12);
    repeat (100) @(posedge mclk_i);
    chk("ir data", ADR_DATA, {24'h0, d}, 32'h0000_00FF);
    $display("test infrared done");
    report_and_stop();
  end
endmodule // ual_line_modes_test
